// ===== jbas_regs.svh
// Constants for the boundary and analog scan test port
`ifndef JBAS_REGS_SVH
`define JBAS_REGS_SVH
`define JBAS_IR_W 3
`define JBAS_IR_EXTEST 3'h0
`define JBAS_IR_ANALOG 3'h2
`define JBAS_IR_SAMPLE 3'h4
`define JBAS_IR_IDCODE 3'h6
`define JBAS_IR_BYPASS 3'h7
`define JBAS_IR_CAPTURE 3'h1
`define JBAS_ASR_W 5
`define JBAS_BSR_W 99
`define JBAS_ID_W 32
`define JBAS_BSR_LOOP_EN 15
`define JBAS_BSR_ACK_EN 51
`define JBAS_BSR_ACK 52
`define JBAS_ANA_TX_BASE 5'h18
`define JBAS_ANA_RX_BASE 5'h10
`endif

// ===== jbas_pkg.sv
// Types for the boundary and analog scan test port
package jbas_pkg;
    typedef enum logic [15:0] {
        JBAS_RESET = 16'h0001, JBAS_IDLE = 16'h0002, JBAS_SEL_DR = 16'h0004,
        JBAS_CAP_DR = 16'h0008, JBAS_SH_DR = 16'h0010, JBAS_EX1_DR = 16'h0020,
        JBAS_PA_DR = 16'h0040, JBAS_EX2_DR = 16'h0080, JBAS_UP_DR = 16'h0100,
        JBAS_SEL_IR = 16'h0200, JBAS_CAP_IR = 16'h0400, JBAS_SH_IR = 16'h0800,
        JBAS_EX1_IR = 16'h1000, JBAS_PA_IR = 16'h2000, JBAS_EX2_IR = 16'h4000,
        JBAS_UP_IR = 16'h8000
    } jbas_tap_t;
endpackage

// ===== jbas_scan_port.sv
// Boundary, analog, identification and bypass scan port with TAP controller
`timescale 1ns/1ps
`include "jbas_regs.svh"
// How it works
// - five-bit analog chain, shifted LSB first
// - codes select transmit or receive channel pair
// - 32-bit identity, fields fixed, bit zero one
// - one-bit bypass stage between TDI and TDO
// - three-bit instruction register shifted LSB first
// - code 000 drives pins from boundary chain
// - code 010 enables analog force and sense
// - code 100 samples pins, functional path kept
// - code 110 selects the identification chain
// - code 111 selects the bypass stage
// - cell 15 disables all loop pin drivers
// - per-channel cell tristates receive outputs
// - cell 51 disables acknowledge drive, 52 value
// - TDO changes on falling TCK edges
// - sixteen-state TAP, reset loads identify instruction
// - boundary chain shifts LSB first, multi-cell pins
module jbas_scan_port
    import jbas_pkg::*;
#(
    parameter logic [3:0] REVISION = 4'h1,       // Arbitrary value
    parameter logic [15:0] PART = 16'h1234,      // Arbitrary value
    parameter logic [10:0] MAKER = 11'h055       // Arbitrary value
) (
    // System side
    input wire logic clk_sys,
    input wire logic reset_n,
    // Test link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Pin values seen by the boundary chain, in chain order
    input wire logic [`JBAS_BSR_W-1:0] pin_in,
    // Core values and enables for pins; enables active high
    input wire logic [`JBAS_BSR_W-1:0] core_out,
    // Values and test-mode overrides toward the pads
    output logic [`JBAS_BSR_W-1:0] pad_out,
    output logic pad_test_mode,
    output logic loop_pins_drive_disable,
    output logic [7:0] receive_outputs_tristate,
    output logic acknowledge_drive_disable,
    // Analog test port steering, one-hot channel selects
    output logic analog_enable,
    output logic [7:0] analog_tx_select,
    output logic [7:0] analog_rx_select
);
    // Control cells of the receive outputs, channels 0 to 7
    localparam int HIZ_CELL [8] = '{30, 22, 44, 36, 71, 63, 86, 78};
    localparam logic [`JBAS_ID_W-1:0] ID_VALUE = {REVISION, PART, MAKER, 1'b1};

    jbas_tap_t st_q, st_d;
    logic [`JBAS_IR_W-1:0] ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [`JBAS_BSR_W-1:0] bsr_q, bsr_d, bsr_up_q, bsr_up_d;
    logic [`JBAS_ASR_W-1:0] asr_q, asr_d, asr_up_q, asr_up_d;
    logic [`JBAS_ID_W-1:0] id_q, id_d;
    logic byp_q, byp_d;
    logic tdo_q, tdo_oe_q;
    logic [1:0] rs_sync_q;
    logic [`JBAS_BSR_W-1:0] pin_s1_q, pin_s2_q;

    // Pins are asynchronous to TCK; two flops each, so a pin must settle two TCK edges early
    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    function automatic logic [2:0] dr_sel(input logic [2:0] ir);
        case (ir)
            `JBAS_IR_EXTEST, `JBAS_IR_SAMPLE: dr_sel = 3'h0;
            `JBAS_IR_ANALOG: dr_sel = 3'h1;
            `JBAS_IR_IDCODE: dr_sel = 3'h2;
            default: dr_sel = 3'h3;
        endcase
    endfunction

    // TAP next state
    always_comb begin
        case (st_q)
            JBAS_RESET: st_d = tms ? JBAS_RESET : JBAS_IDLE;
            JBAS_IDLE: st_d = tms ? JBAS_SEL_DR : JBAS_IDLE;
            JBAS_SEL_DR: st_d = tms ? JBAS_SEL_IR : JBAS_CAP_DR;
            JBAS_CAP_DR: st_d = tms ? JBAS_EX1_DR : JBAS_SH_DR;
            JBAS_SH_DR: st_d = tms ? JBAS_EX1_DR : JBAS_SH_DR;
            JBAS_EX1_DR: st_d = tms ? JBAS_UP_DR : JBAS_PA_DR;
            JBAS_PA_DR: st_d = tms ? JBAS_EX2_DR : JBAS_PA_DR;
            JBAS_EX2_DR: st_d = tms ? JBAS_UP_DR : JBAS_SH_DR;
            JBAS_UP_DR: st_d = tms ? JBAS_SEL_DR : JBAS_IDLE;
            JBAS_SEL_IR: st_d = tms ? JBAS_RESET : JBAS_CAP_IR;
            JBAS_CAP_IR: st_d = tms ? JBAS_EX1_IR : JBAS_SH_IR;
            JBAS_SH_IR: st_d = tms ? JBAS_EX1_IR : JBAS_SH_IR;
            JBAS_EX1_IR: st_d = tms ? JBAS_UP_IR : JBAS_PA_IR;
            JBAS_PA_IR: st_d = tms ? JBAS_EX2_IR : JBAS_PA_IR;
            JBAS_EX2_IR: st_d = tms ? JBAS_UP_IR : JBAS_SH_IR;
            JBAS_UP_IR: st_d = tms ? JBAS_SEL_DR : JBAS_IDLE;
            default: st_d = JBAS_RESET;
        endcase
    end

    // Shift and capture of all chains; update of instruction, boundary and analog chains only
    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d = ir_q;
        bsr_d = bsr_q;
        bsr_up_d = bsr_up_q;
        asr_d = asr_q;
        asr_up_d = asr_up_q;
        id_d = id_q;
        byp_d = byp_q;
        case (st_q)
            JBAS_RESET: begin
                ir_d = `JBAS_IR_IDCODE;
                asr_up_d = '0;
            end
            JBAS_CAP_IR: ir_sh_d = `JBAS_IR_CAPTURE;
            JBAS_SH_IR: ir_sh_d = {tdi, ir_sh_q[`JBAS_IR_W-1:1]};
            JBAS_UP_IR: ir_d = ir_sh_q;
            JBAS_CAP_DR: begin
                case (dr_sel(ir_q))
                    3'h0: bsr_d = pin_s2_q;
                    3'h1: asr_d = asr_up_q;
                    3'h2: id_d = ID_VALUE;
                    default: byp_d = 1'b0;
                endcase
            end
            JBAS_SH_DR: begin
                case (dr_sel(ir_q))
                    3'h0: bsr_d = {tdi, bsr_q[`JBAS_BSR_W-1:1]};
                    3'h1: asr_d = {tdi, asr_q[`JBAS_ASR_W-1:1]};
                    3'h2: id_d = {tdi, id_q[`JBAS_ID_W-1:1]};
                    default: byp_d = tdi;
                endcase
            end
            JBAS_UP_DR: begin
                if (dr_sel(ir_q) == 3'h0) begin
                    bsr_up_d = bsr_q;
                end
                if (dr_sel(ir_q) == 3'h1) begin
                    asr_up_d = asr_q;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= JBAS_RESET;
            ir_sh_q <= '0;
            ir_q <= `JBAS_IR_IDCODE;
            bsr_q <= '0;
            bsr_up_q <= '0;
            asr_q <= '0;
            asr_up_q <= '0;
            id_q <= '0;
            byp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
            bsr_q <= bsr_d;
            bsr_up_q <= bsr_up_d;
            asr_q <= asr_d;
            asr_up_q <= asr_up_d;
            id_q <= id_d;
            byp_q <= byp_d;
        end
    end

    // Serial output mux, registered on the falling edge
    logic tdo_d, tdo_oe_d;
    always_comb begin
        tdo_oe_d = (st_q == JBAS_SH_DR) || (st_q == JBAS_SH_IR);
        if (st_q == JBAS_SH_IR) begin
            tdo_d = ir_sh_q[0];
        end else begin
            case (dr_sel(ir_q))
                3'h0: tdo_d = bsr_q[0];
                3'h1: tdo_d = asr_q[0];
                3'h2: tdo_d = id_q[0];
                default: tdo_d = byp_q;
            endcase
        end
    end

    always_ff @(negedge tck or negedge reset_n) begin
        if (!reset_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_q <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end
    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // Pad and analog controls, all registered on TCK
    logic [`JBAS_BSR_W-1:0] pad_d;
    logic test_d, loop_dis_d, ack_dis_d, ana_en_d;
    logic [7:0] rx_hiz_d, tx_sel_d, rx_sel_d;
    always_comb begin
        test_d = (ir_q == `JBAS_IR_EXTEST);
        pad_d = test_d ? bsr_up_q : core_out;
        loop_dis_d = test_d ? bsr_up_q[`JBAS_BSR_LOOP_EN] : 1'b0;
        ack_dis_d = test_d ? bsr_up_q[`JBAS_BSR_ACK_EN] : 1'b0;
        for (int i = 0; i < 8; i++) begin
            rx_hiz_d[i] = test_d ? bsr_up_q[HIZ_CELL[i]] : 1'b0;
        end
        ana_en_d = (ir_q == `JBAS_IR_ANALOG);
        tx_sel_d = '0;
        rx_sel_d = '0;
        if (ana_en_d && asr_up_q[4]) begin
            for (int c = 0; c < 8; c++) begin
                if (asr_up_q[2:0] == 3'(7 - c)) begin
                    tx_sel_d[c] = asr_up_q[3];
                    rx_sel_d[c] = !asr_up_q[3];
                end
            end
        end
    end

    always_ff @(posedge tck or negedge reset_n) begin
        if (!reset_n) begin
            pad_out <= '0;
            pad_test_mode <= 1'b0;
            loop_pins_drive_disable <= 1'b0;
            receive_outputs_tristate <= '0;
            acknowledge_drive_disable <= 1'b0;
            analog_enable <= 1'b0;
            analog_tx_select <= '0;
            analog_rx_select <= '0;
        end else begin
            pad_out <= pad_d;
            pad_test_mode <= test_d;
            loop_pins_drive_disable <= loop_dis_d;
            receive_outputs_tristate <= rx_hiz_d;
            acknowledge_drive_disable <= ack_dis_d;
            analog_enable <= ana_en_d;
            analog_tx_select <= tx_sel_d;
            analog_rx_select <= rx_sel_d;
        end
    end

    // System-clock side: reset observed through a two-stage synchroniser
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rs_sync_q <= 2'h0;
        end else begin
            rs_sync_q <= {rs_sync_q[0], 1'b1};
        end
    end

    property p_reset_loads_id;
        @(posedge tck) disable iff (!reset_n)
        st_q == JBAS_RESET |=> ir_q == `JBAS_IR_IDCODE;
    endproperty
    a_reset_loads_id: assert property (p_reset_loads_id) else $error("reset lost id");

    property p_five_tms_reset;
        @(posedge tck) disable iff (!reset_n)
        tms [*5] |=> st_q == JBAS_RESET;
    endproperty
    a_five_tms_reset: assert property (p_five_tms_reset) else $error("tap no reset");

    sequence s_byp_shift;
        st_q == JBAS_SH_DR && dr_sel(ir_q) == 3'h3;
    endsequence
    property p_bypass;
        @(posedge tck) disable iff (!reset_n)
        s_byp_shift |=> byp_q == $past(tdi);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass wrong");

    property p_id_capture;
        @(posedge tck) disable iff (!reset_n)
        st_q == JBAS_CAP_DR && ir_q == `JBAS_IR_IDCODE |=> id_q[0] == 1'b1;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id bit0");

    property p_ir_shift;
        @(posedge tck) disable iff (!reset_n)
        st_q == JBAS_SH_IR |=> ir_sh_q[2] == $past(tdi);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("ir shift");

    property p_test_mode;
        @(posedge tck) disable iff (!reset_n)
        ir_q == `JBAS_IR_EXTEST |=> pad_test_mode && pad_out == $past(bsr_up_q);
    endproperty
    a_test_mode: assert property (p_test_mode) else $error("extest pads");

    property p_sample_func;
        @(posedge tck) disable iff (!reset_n)
        ir_q == `JBAS_IR_SAMPLE |=> !pad_test_mode && pad_out == $past(core_out);
    endproperty
    a_sample_func: assert property (p_sample_func) else $error("sample path");

    property p_analog_tx0;
        @(posedge tck) disable iff (!reset_n)
        ir_q == `JBAS_IR_ANALOG && asr_up_q == 5'h1F |=> analog_tx_select == 8'h01;
    endproperty
    a_analog_tx0: assert property (p_analog_tx0) else $error("analog code");

    property p_tdo_falling;
        @(negedge tck) disable iff (!reset_n)
        st_q == JBAS_SH_DR && dr_sel(ir_q) == 3'h3 |=> tdo == $past(byp_q);
    endproperty
    a_tdo_falling: assert property (p_tdo_falling) else $error("tdo timing");
endmodule

// ===== jbas_jtag_host.sv
// Test controller model that steps the scan port through its TAP states
`timescale 1ns/1ps
module jbas_jtag_host (
    // Test link
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    int edge_faults = 0;
    int oe_faults = 0;
    logic oe_seen;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Clock stands still between calls; tdo read just before the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdo;
        oe_seen = tdo_oe;
        tck = 1'b1;
        #1;
        // A rising-edge update of tdo would corrupt the next bit seen
        if (tdo !== q) edge_faults++;
        #61.5;
        tck = 1'b0;
    endtask
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
    task automatic scan(input logic ir, input int n, input logic [98:0] din,
                        output logic [98:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            // Output enable must stand while a shift state drives tdo
            if (oe_seen !== 1'b1) oe_faults++;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        if (oe_seen !== 1'b0) oe_faults++;
    endtask
endmodule

// ===== jbas_scan_port_bench.sv
// Self-checking bench for the scan port
`timescale 1ns/1ps
`include "jbas_regs.svh"
module jbas_scan_port_bench import jbas_pkg::*; ;
    logic clk_sys, reset_n, tck, tms, tdi, tdo, tdo_oe, pad_test_mode;
    logic loop_pins_drive_disable, acknowledge_drive_disable, analog_enable;
    logic [98:0] pin_in, core_out, pad_out, d, p;
    logic [7:0] receive_outputs_tristate, analog_tx_select, analog_rx_select;
    int bad_count = 0;
    int total_checks = 0;
    jbas_scan_port i_jbas_scan_port (.clk_sys(clk_sys), .reset_n(reset_n), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in),
        .core_out(core_out), .pad_out(pad_out), .pad_test_mode(pad_test_mode),
        .loop_pins_drive_disable(loop_pins_drive_disable),
        .receive_outputs_tristate(receive_outputs_tristate),
        .acknowledge_drive_disable(acknowledge_drive_disable),
        .analog_enable(analog_enable), .analog_tx_select(analog_tx_select),
        .analog_rx_select(analog_rx_select));
    jbas_jtag_host i_jbas_jtag_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [98:0] seen, input logic [98:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s seen=%h exp=%h", $time, msg, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic load_ir(input logic [2:0] code);
        i_jbas_jtag_host.scan(1'b1, 3, 99'(code), d);
        check(99'(d[2:0]), 99'(3'h1), "ir capture");
    endtask
    task automatic t_idcode();
        i_jbas_jtag_host.scan(1'b0, 32, '0, d);
        check(99'(d[31:0]), 99'({4'h1, 16'h1234, 11'h055, 1'b1}), "id after reset");
        load_ir(3'h7);
        i_jbas_jtag_host.reset_tap();
        i_jbas_jtag_host.scan(1'b0, 32, '0, d);
        check(99'(d[31:0]), 99'({4'h1, 16'h1234, 11'h055, 1'b1}), "id after tms reset");
        load_ir(3'h6);
        i_jbas_jtag_host.scan(1'b0, 32, '0, d);
        check(99'(d[31:0]), 99'({4'h1, 16'h1234, 11'h055, 1'b1}), "id");
    endtask
    task automatic t_extest();
        load_ir(3'h0);
        p = ~pin_in;
        i_jbas_jtag_host.scan(1'b0, 99, p, d);
        check(d, pin_in, "extest capture");
        check(pad_out, p, "extest drive");
        check(99'(pad_test_mode), 99'(1'b1), "test mode");
        check(99'(loop_pins_drive_disable), 99'(p[15]), "loop ctl");
        check(99'(receive_outputs_tristate), 99'({p[78], p[86], p[63], p[71], p[36],
            p[44], p[22], p[30]}), "rx ctl");
        check(99'(acknowledge_drive_disable), 99'(p[51]), "ack ctl");
    endtask
    task automatic t_sample();
        load_ir(3'h4);
        @(negedge clk_sys);
        pin_in = {3'h2, 32'h0F1E_2D3C, 32'h4B5A_6978, 32'h8796_A5B4};
        i_jbas_jtag_host.scan(1'b0, 99, ~core_out, d);
        check(d, pin_in, "sample capture");
        check(pad_out, core_out, "functional path");
        check(99'({pad_test_mode, loop_pins_drive_disable, receive_outputs_tristate,
            acknowledge_drive_disable, analog_enable}), '0, "sample ctl");
    endtask
    task automatic t_analog();
        logic [7:0] ch;
        load_ir(3'h2);
        check(99'(analog_enable), 99'(1'b1), "analog on");
        for (int c = 0; c < 16; c++) begin
            i_jbas_jtag_host.scan(1'b0, 5, 99'(5'h10 + c), d);
            ch = 8'h01 << (7 - c[2:0]);
            check(99'({analog_tx_select, analog_rx_select}),
                99'(c[3] ? {ch, 8'h00} : {8'h00, ch}), "analog code");
        end
    endtask
    task automatic t_bypass();
        logic [2:0] codes [4] = '{3'h7, 3'h1, 3'h3, 3'h5};
        foreach (codes[k]) begin
            load_ir(codes[k]);
            i_jbas_jtag_host.scan(1'b0, 8, 99'(8'h96), d);
            check(99'(d[7:0]), 99'(8'h2C), "bypass");
            check(99'(analog_enable), '0, "analog off");
        end
    endtask
    initial begin
        reset_n = 1'b0;
        pin_in = {3'h5, 32'hA5C3_0F96, 32'h1234_5678, 32'hDEAD_BEEF};
        core_out = {3'h6, 32'h3C69_96C3, 32'hF00F_5AA5, 32'h0123_4567};
        fork
            begin
                repeat (5) @(negedge clk_sys);
                reset_n = 1'b1;
            end
            i_jbas_jtag_host.reset_tap();
        join
        t_idcode();
        t_extest();
        t_sample();
        t_analog();
        t_bypass();
        check(99'(i_jbas_jtag_host.edge_faults), '0, "tdo edge");
        check(99'(i_jbas_jtag_host.oe_faults), '0, "tdo enable");
        results();
    end
    initial begin
        #1000000;
        bad_count++;
        results();
    end
endmodule
